// File: rtl/riu_pkg.sv
// Constants for the rotate instruction unit.
// Assumes a 12-bit file register space with a 4-bit bank select register.
package riu_pkg;
  localparam int unsigned riu_data_w = 8;
  localparam int unsigned riu_bank_w = 4;
  localparam logic [7:0] riu_ilo_limit = 8'h5f;
  localparam logic [7:0] riu_access_split = 8'h60;
  localparam logic [3:0] riu_access_hi_bank = 4'hf;
  localparam logic [15:0] riu_op_rl_val = 16'h4400;
  localparam logic [15:0] riu_op_rr_val = 16'h3000;
  localparam logic [15:0] riu_op_mask = 16'hfc00;
  localparam int unsigned riu_d_bit = 9;
  localparam int unsigned riu_a_bit = 8;
  localparam logic [7:0] riu_w_rst = 8'h00;
  localparam logic [7:0] riu_wdata_rst = 8'h00;
  localparam logic [11:0] riu_addr_rst = 12'h000;
  localparam logic riu_flag_rst = 1'b0;
endpackage

// File: rtl/riu_rotate_unit.sv
// Rotate instruction unit: executes the two rotate instructions in one cycle.
// Assumes the core supplies the instruction word, a strobe and read data for
// the addressed file register in the same cycle, combinationally.
// Notes on behaviour
// - Right rotate through carry shifts toward bit zero, carry is ninth bit.
// - Right rotate: bit n to n-1, bit 0 to carry, carry to bit 7.
// - Left rotate: bit n to n+1, bit 7 wraps to bit 0, carry untouched.
// - Destination bit 0 writes working register, file register left unchanged.
// - Destination bit 1 writes the result back into the source file register.
// - Bank bit 0 selects access bank; 1 uses bank select register.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module riu_rotate_unit
(
  input wire logic clk, // Instruction clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic instr_valid, // One-cycle strobe with a new instruction.
  input wire logic [15:0] instr_word, // Instruction word.
  input wire logic ext_set_en, // Extended instruction set enabled.
  input wire logic [3:0] bank_select_register, // Bank select value.
  input wire logic [7:0] index_base, // Index pointer base for literal offset mode.
  input wire logic [7:0] file_rdata, // Data of the addressed file register.
  output logic [11:0] file_addr, // Full file register address.
  output logic file_we, // Write strobe for the file register.
  output logic [7:0] file_wdata, // Data written to the file register.
  output logic [11:0] file_waddr, // Address of the register being written back.
  output logic [7:0] w_reg, // Working register.
  output logic carry, // Carry flag.
  output logic zero, // Zero flag.
  output logic negative, // Negative flag.
  output logic busy // Never set: every rotate completes in one cycle.
);
  ////////////////////////////////////////////////////////////////////////////
  logic is_rl, is_rr, hit, dsel, asel;
  logic [7:0] faddr, result;
  logic [7:0] w_q, wd_q;
  logic c_q, z_q, n_q, we_q;
  logic [11:0] fa_q;

  assign is_rl = (instr_word & riu_pkg::riu_op_mask) == riu_pkg::riu_op_rl_val;
  assign is_rr = (instr_word & riu_pkg::riu_op_mask) == riu_pkg::riu_op_rr_val;
  assign hit = instr_valid && (is_rl || is_rr);
  assign dsel = instr_word[riu_pkg::riu_d_bit];
  assign asel = instr_word[riu_pkg::riu_a_bit];
  assign faddr = instr_word[7:0];

  // Indexed mode wraps inside bank zero: a base near the top of the bank
  // folds the operand back to the bottom rather than into bank one.
  // address formation
  always_comb
  begin
    if (asel)
      file_addr = {bank_select_register, faddr};
    else if (ext_set_en && faddr <= riu_pkg::riu_ilo_limit)
      file_addr = {4'h0, 8'(index_base + faddr)};
    else if (faddr < riu_pkg::riu_access_split)
      file_addr = {4'h0, faddr};
    else
      file_addr = {riu_pkg::riu_access_hi_bank, faddr};
  end

  // The right rotate reads the registered carry, so a rotate issued on the
  // very next edge already sees the carry left by the one before.
  // rotate datapath
  always_comb
  begin
    if (is_rr)
      result = {c_q, file_rdata[7:1]};
    else
      result = {file_rdata[6:0], file_rdata[7]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register destination
  always_ff @(posedge clk)
  begin
    if (srst)
      w_q <= riu_pkg::riu_w_rst;
    else if (hit && !dsel)
      w_q <= result;
  end

  // The address is captured at issue: by the write cycle the combinational
  // address already belongs to the next instruction.
  // file register write back
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      we_q <= 1'b0;
      wd_q <= riu_pkg::riu_wdata_rst;
      fa_q <= riu_pkg::riu_addr_rst;
    end
    else
    begin
      we_q <= hit && dsel;
      if (hit && dsel)
      begin
        wd_q <= result;
        fa_q <= file_addr;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      c_q <= riu_pkg::riu_flag_rst;
      z_q <= riu_pkg::riu_flag_rst;
      n_q <= riu_pkg::riu_flag_rst;
    end
    else if (hit)
    begin
      z_q <= result == 8'h00;
      n_q <= result[7];
      if (is_rr)
        c_q <= file_rdata[0];
    end
  end

  assign w_reg = w_q;
  assign file_we = we_q;
  assign file_wdata = wd_q;
  assign file_waddr = fa_q;
  assign carry = c_q;
  assign zero = z_q;
  assign negative = n_q;
  assign busy = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Every result is registered, so the result and flag checks look one edge past the issue
  // and use $past to recover the operand and carry that the issue saw.
  sequence s_rr_issue;
    hit && is_rr;
  endsequence

  sequence s_rl_issue;
    hit && is_rl;
  endsequence

  sequence s_file_dest;
    hit && dsel;
  endsequence

  sequence s_work_dest;
    hit && !dsel;
  endsequence

  a_rr_result: assert property (@(posedge clk) disable iff (srst)
    s_rr_issue ##0 dsel
    |=> file_we && file_wdata == {$past(carry), $past(file_rdata[7:1])})
    else $error("right rotate result wrong");

  a_rr_work: assert property (@(posedge clk) disable iff (srst)
    s_rr_issue ##0 !dsel
    |=> w_reg == {$past(carry), $past(file_rdata[7:1])})
    else $error("right rotate working result wrong");

  a_rr_carry: assert property (@(posedge clk) disable iff (srst)
    s_rr_issue |=> carry == $past(file_rdata[0]))
    else $error("right rotate carry wrong");

  a_rl_wrap: assert property (@(posedge clk) disable iff (srst)
    s_rl_issue ##0 !dsel
    |=> w_reg == {$past(file_rdata[6:0]), $past(file_rdata[7])})
    else $error("left rotate result wrong");

  a_rl_file: assert property (@(posedge clk) disable iff (srst)
    s_rl_issue ##0 dsel
    |=> file_we && file_wdata == {$past(file_rdata[6:0]), $past(file_rdata[7])})
    else $error("left rotate file result wrong");

  a_rl_carry_kept: assert property (@(posedge clk) disable iff (srst)
    s_rl_issue |=> $stable(carry))
    else $error("left rotate changed carry");

  a_w_dest_nowrite: assert property (@(posedge clk) disable iff (srst)
    s_work_dest |=> !file_we && $stable(file_wdata))
    else $error("file written for working destination");

  a_we_only_file: assert property (@(posedge clk) disable iff (srst)
    !(hit && dsel) |=> !file_we)
    else $error("file write without a file destination");

  a_f_dest_keep_w: assert property (@(posedge clk) disable iff (srst)
    s_file_dest
    |=> file_we && $stable(w_reg) && file_waddr == $past(file_addr))
    else $error("file destination misbehaved");

  a_bank_addr: assert property (@(posedge clk) disable iff (srst)
    hit && asel |-> file_addr == {bank_select_register, faddr})
    else $error("banked address wrong");

  a_access_addr: assert property (@(posedge clk) disable iff (srst)
    hit && !asel && !(ext_set_en && faddr <= riu_pkg::riu_ilo_limit)
    |-> file_addr == {(faddr < riu_pkg::riu_access_split) ? 4'h0 : riu_pkg::riu_access_hi_bank, faddr})
    else $error("access bank address wrong");

  a_index_addr: assert property (@(posedge clk) disable iff (srst)
    hit && !asel && ext_set_en && faddr <= riu_pkg::riu_ilo_limit
    |-> file_addr == {4'h0, 8'(index_base + faddr)})
    else $error("indexed address wrong");

  a_zero_flag: assert property (@(posedge clk) disable iff (srst)
    hit
    |=> zero == ($past(dsel) ? file_wdata == 8'h00 : w_reg == 8'h00)
    && negative == ($past(dsel) ? file_wdata[7] : w_reg[7]))
    else $error("zero or negative flag wrong");

  a_refused_quiet: assert property (@(posedge clk) disable iff (srst)
    !hit
    |=> $stable(w_reg) && $stable(carry) && $stable(zero) && $stable(negative) && !file_we)
    else $error("state changed without a rotate");
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the rotate instruction unit.
// Assumes one 125 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, srst, instr_valid, ext_set_en, file_we, carry, zero, negative, busy;
  logic [15:0] instr_word;
  logic [3:0] bank_select_register;
  logic [7:0] index_base, file_rdata, file_wdata, w_reg;
  logic [11:0] file_addr, file_waddr;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] exp_w = 8'h00;
  logic exp_c = 1'b0;
  riu_rotate_unit uut (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr_word(instr_word),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register), .index_base(index_base),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .file_waddr(file_waddr),
    .w_reg(w_reg), .carry(carry), .zero(zero), .negative(negative), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Issues one rotate, then checks address, result, flags and destination.
  task automatic exec(input bit right, input bit d, input bit a, input logic [7:0] f, input logic [7:0] x);
    logic [7:0] r;
    logic [11:0] ea;
    r = right ? {exp_c, x[7:1]} : {x[6:0], x[7]};
    if (right)
      exp_c = x[0];
    if (!d)
      exp_w = r;
    @(posedge clk);
    // Mode inputs the caller changed just before have settled by this edge.
    ea = a ? {bank_select_register, f} : (ext_set_en && f <= 8'h5f) ? {4'h0, index_base + f}
      : {(f < 8'h60) ? 4'h0 : 4'hf, f};
    instr_valid <= 1'b1;
    instr_word <= (right ? riu_pkg::riu_op_rr_val : riu_pkg::riu_op_rl_val) | {6'h00, d, a, f};
    file_rdata <= x;
    @(negedge clk) check(file_addr, ea, "address");
    @(posedge clk);
    instr_valid <= 1'b0;
    file_rdata <= ~x;
    @(negedge clk) check({file_we, carry, zero, negative, w_reg}, {d, exp_c, r == 8'h00, r[7], exp_w}, "result");
    if (d)
    begin
      check({4'h0, file_wdata}, {4'h0, r}, "write data");
      check(file_waddr, ea, "write address");
    end
    check({11'h000, busy}, 12'h000, "busy");
    $display("test rotate right=%0d d=%0d a=%0d done at %0t", right, d, a, $time);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    bank_select_register = 4'h3;
    index_base = 8'h20;
    file_rdata = 8'h00;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk) check({file_we, carry, zero, negative, w_reg}, 12'h000, "reset");
    check({busy, 3'h0, file_wdata}, 12'h000, "reset data");
    exec(1'b0, 1'b0, 1'b0, 8'h10, 8'hab);
    exec(1'b1, 1'b1, 1'b1, 8'h80, 8'h01);
    exec(1'b1, 1'b0, 1'b0, 8'hf0, 8'h00);
    exec(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    @(posedge clk) ext_set_en <= 1'b1;
    exec(1'b0, 1'b0, 1'b0, 8'h5f, 8'h81);
    exec(1'b1, 1'b1, 1'b0, 8'h60, 8'h7e);
    exec(1'b1, 1'b0, 1'b1, 8'h05, 8'hc3);
    exec(1'b0, 1'b0, 1'b0, 8'h40, 8'h80);
    @(posedge clk) index_base <= 8'hf0;
    exec(1'b1, 1'b1, 1'b0, 8'h20, 8'h55);
    // Back-to-back issue: the second right rotate consumes the carry of the first.
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= riu_pkg::riu_op_rr_val | 16'h0310;
    file_rdata <= 8'h02;
    @(posedge clk);
    instr_word <= riu_pkg::riu_op_rr_val | 16'h0011;
    file_rdata <= 8'h81;
    @(negedge clk) check({2'h0, file_we, carry, file_wdata}, 12'h281, "first of pair");
    check(file_waddr, 12'h310, "pair write address");
    check(file_addr, 12'h001, "indexed wrap");
    @(posedge clk);
    instr_word <= 16'h4210;
    file_rdata <= 8'h00;
    @(negedge clk) check({file_we, carry, zero, negative, w_reg}, 12'h440, "second of pair");
    @(posedge clk);
    instr_valid <= 1'b0;
    instr_word <= riu_pkg::riu_op_rl_val | 16'h0210;
    @(negedge clk) check({file_we, carry, zero, negative, w_reg}, 12'h440, "ignored word");
    @(posedge clk);
    @(negedge clk) check({file_we, carry, zero, negative, w_reg}, 12'h440, "idle strobe");
    $display("test back-to-back and ignored words done at %0t", $time);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    exp_w = 8'h00;
    exp_c = 1'b0;
    @(negedge clk) check({file_we, carry, zero, negative, w_reg}, 12'h000, "second reset");
    check({busy, 3'h0, file_wdata}, 12'h000, "second reset data");
    $display("test mid-run reset done at %0t", $time);
    exec(1'b1, 1'b0, 1'b0, 8'h61, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
